// ### core/anp_params.svh
// Purpose: offsets, field positions and reset values of the bank
// Assumes: register index times four gives the byte address
// Notes: definitions only
`ifndef ANP_PARAMS_SVH
`define ANP_PARAMS_SVH

`define ANP_ADDR_W 8
`define ANP_IDX_EXP 6'h06
`define ANP_IDX_LNP 6'h07
`define ANP_IDX_PNP 6'h08
`define ANP_IDX_PRE 6'h14
`define ANP_IDX_ISTS 6'h30
`define ANP_IDX_IEN 6'h31

`define ANP_EXP_PDF 4
`define ANP_EXP_LPNP 3
`define ANP_EXP_NPA 2
`define ANP_EXP_PGR 1
`define ANP_EXP_LPAN 0

`define ANP_NP_TOG 11
`define ANP_LNP_RST 16'h2001
`define ANP_LNP_WR_MASK 16'hb7ff

`define ANP_PRE_100 7
`define ANP_PRE_10 6
`define ANP_PRE_RSV_LOW 6'h01
`define ANP_STRAP_100 3'b100
`define ANP_STRAP_WAIT 2'h2

`define ANP_IRQ_N 2
`define ANP_IRQ_PDF 0
`define ANP_IRQ_PGR 1

`define ANP_DROP_100 4'h2
`define ANP_DROP_10 4'he

`endif

// ### core/anp_pkg.sv
// Purpose: shared types of the next-page register bank
// Assumes: nothing beyond the params header
// Notes: constants live in anp_params.svh
package anp_pkg;
    typedef enum logic [1:0] {
        ANP_RESP_OKAY = 2'b00,
        ANP_RESP_SLVERR = 2'b10
    } anp_resp_t;

    typedef enum logic [1:0] {
        ANP_PF_IDLE = 2'b00,
        ANP_PF_DROP = 2'b01,
        ANP_PF_PASS = 2'b10
    } anp_pf_state_t;
endpackage

// ### core/anp_reg_if.sv
// Purpose: register access strobes between bus slave and register file
// Assumes: single clock
// Notes: hits are decoded by the register side
`timescale 1ns/1ps
`include "anp_params.svh"
interface anp_reg_if;
    logic wr_en;
    logic [`ANP_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [`ANP_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface // anp_reg_if

// ### core/anp_axil_slave.sv
// Purpose: AXI4-Lite slave feeding the register strobes
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer SLVERR
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ANP_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output anp_pkg::anp_resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ANP_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output anp_pkg::anp_resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    anp_reg_if.bus rb
);
    import anp_pkg::*;
    logic aw_got_r;
    logic w_got_r;
    logic rd_pend_r;
    logic [`ANP_ADDR_W-1:0] wa_r;
    logic [`ANP_ADDR_W-1:0] ra_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    wire do_wr = aw_got_r & w_got_r & ~bvalid;

    assign rb.wr_en = do_wr;
    assign rb.wr_addr = wa_r;
    assign rb.wr_data = wd_r;
    assign rb.wr_strb = ws_r;
    assign rb.rd_en = rd_pend_r;
    assign rb.rd_addr = ra_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= ANP_RESP_OKAY;
            wa_r <= '0;
            wd_r <= '0;
            ws_r <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got_r <= 1'b1;
                wa_r <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got_r <= 1'b1;
                wd_r <= wdata;
                ws_r <= wstrb;
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= rb.wr_ok ? ANP_RESP_OKAY : ANP_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rd_pend_r <= 1'b0;
            ra_r <= '0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ANP_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rd_pend_r <= 1'b1;
                ra_r <= araddr;
            end
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rb.rd_ok ? rb.rd_data : 32'h0000_0000;
                rresp <= rb.rd_ok ? ANP_RESP_OKAY : ANP_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // anp_axil_slave

// ### core/anp_preamble_filter.sv
// Purpose: drop or keep received preamble nibbles on the MII path
// Assumes: nibble stream on aclk, one nibble per cycle while dv high
// Notes: one cycle of fixed delay in every mode
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_preamble_filter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic speed_100,
    input wire logic restore_100,
    input wire logic restore_10,
    input wire logic rx_dv_in,
    input wire logic [3:0] rxd_in,
    output logic rx_dv_out,
    output logic [3:0] rxd_out
);
    import anp_pkg::*;
    anp_pf_state_t state_r;
    logic [3:0] cnt_r;
    wire [3:0] drop = speed_100 ? (restore_100 ? 4'h0 : `ANP_DROP_100)
                                : (restore_10 ? 4'h0 : `ANP_DROP_10);
    wire pass_now = (state_r == ANP_PF_PASS) ||
                    (state_r == ANP_PF_IDLE && drop == 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ANP_PF_IDLE;
            cnt_r <= 4'h0;
            rx_dv_out <= 1'b0;
            rxd_out <= 4'h0;
        end else begin
            rx_dv_out <= rx_dv_in & pass_now;
            rxd_out <= (rx_dv_in & pass_now) ? rxd_in : 4'h0;
            if (!rx_dv_in) begin
                state_r <= ANP_PF_IDLE;
            end else begin
                case (state_r)
                    ANP_PF_IDLE: begin
                        cnt_r <= drop - 4'h1;
                        state_r <= pass_now ? ANP_PF_PASS : ANP_PF_DROP;
                    end
                    ANP_PF_DROP: begin
                        cnt_r <= cnt_r - 4'h1;
                        if (cnt_r == 4'h1) begin
                            state_r <= ANP_PF_PASS;
                        end
                    end
                    default: state_r <= ANP_PF_PASS;
                endcase
            end
        end
    end
endmodule // anp_preamble_filter

// ### core/anp_regs_top.sv
// Purpose: expansion, next-page and preamble control registers
// Assumes: negotiation and receive logic share aclk; strap pins async
// Notes: registers are word aligned at four times their index
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_regs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ANP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output anp_pkg::anp_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ANP_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output anp_pkg::anp_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] config_strap,
    input wire logic speed_100,
    input wire logic par_det_fault,
    input wire logic lp_next_page_able,
    input wire logic lp_autoneg_able,
    input wire logic page_rx_stb,
    input wire logic [15:0] partner_word,
    input wire logic np_tx_stb,
    input wire logic rx_dv_in,
    input wire logic [3:0] rxd_in,
    output logic [15:0] np_word_out,
    output logic preamble_100_restore,
    output logic preamble_10_restore,
    output logic rx_dv_out,
    output logic [3:0] rxd_out,
    output logic irq
);
    import anp_pkg::*;

    anp_reg_if rb ();

    logic [2:0] strap_s1_r;
    logic [2:0] strap_s2_r;
    logic [1:0] strap_cnt_r;
    logic strap_done_r;
    logic pdf_lh_r;
    logic pgr_lh_r;
    logic [15:0] lnp_r;
    logic [15:0] lnp_nxt;
    logic toggle_r;
    logic [15:0] pnp_r;
    logic pre100_r;
    logic pre10_r;
    logic [`ANP_IRQ_N-1:0] ists_r;
    logic [`ANP_IRQ_N-1:0] ien_r;
    logic [`ANP_IRQ_N-1:0] irq_evt;
    logic [31:0] rd_mux;

    // address decode on the low byte of each channel
    wire wr_exp = rb.wr_addr == {`ANP_IDX_EXP, 2'b00};
    wire wr_lnp = rb.wr_addr == {`ANP_IDX_LNP, 2'b00};
    wire wr_pnp = rb.wr_addr == {`ANP_IDX_PNP, 2'b00};
    wire wr_pre = rb.wr_addr == {`ANP_IDX_PRE, 2'b00};
    wire wr_ists = rb.wr_addr == {`ANP_IDX_ISTS, 2'b00};
    wire wr_ien = rb.wr_addr == {`ANP_IDX_IEN, 2'b00};
    wire rd_exp = rb.rd_addr == {`ANP_IDX_EXP, 2'b00};
    wire rd_lnp = rb.rd_addr == {`ANP_IDX_LNP, 2'b00};
    wire rd_pnp = rb.rd_addr == {`ANP_IDX_PNP, 2'b00};
    wire rd_pre = rb.rd_addr == {`ANP_IDX_PRE, 2'b00};
    wire rd_ists = rb.rd_addr == {`ANP_IDX_ISTS, 2'b00};
    wire rd_ien = rb.rd_addr == {`ANP_IDX_IEN, 2'b00};

    // read-only registers still accept writes; the data is dropped
    assign rb.wr_ok = wr_exp | wr_lnp | wr_pnp | wr_pre | wr_ists | wr_ien;
    assign rb.rd_ok = rd_exp | rd_lnp | rd_pnp | rd_pre | rd_ists | rd_ien;

    wire [15:0] be16 = {{8{rb.wr_strb[1]}}, {8{rb.wr_strb[0]}}};
    wire lnp_we = rb.wr_en & wr_lnp;
    wire pre_we = rb.wr_en & wr_pre & rb.wr_strb[0];
    wire ists_we = rb.wr_en & wr_ists & rb.wr_strb[0];
    wire ien_we = rb.wr_en & wr_ien & rb.wr_strb[0];
    wire exp_rd = rb.rd_en & rd_exp;
    wire [15:0] lnp_m = be16 & `ANP_LNP_WR_MASK;
    wire [`ANP_IRQ_N-1:0] w1c = ists_we ?
        rb.wr_data[`ANP_IRQ_N-1:0] : {`ANP_IRQ_N{1'b0}};

    assign lnp_nxt = lnp_we ? ((lnp_r & ~lnp_m) | (rb.wr_data[15:0] & lnp_m))
                            : lnp_r;

    wire [15:0] lnp_view = {lnp_r[15:12], toggle_r, lnp_r[10:0]};

    wire [15:0] exp_view = {11'h000, pdf_lh_r, lp_next_page_able, 1'b1,
                            pgr_lh_r, lp_autoneg_able};

    wire [15:0] pre_view = {8'h00, pre100_r, pre10_r, `ANP_PRE_RSV_LOW};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_exp) begin
            rd_mux = {16'h0000, exp_view};
        end else if (rd_lnp) begin
            rd_mux = {16'h0000, lnp_view};
        end else if (rd_pnp) begin
            rd_mux = {16'h0000, pnp_r};
        end else if (rd_pre) begin
            rd_mux = {16'h0000, pre_view};
        end else if (rd_ists) begin
            rd_mux = {{(32-`ANP_IRQ_N){1'b0}}, ists_r};
        end else if (rd_ien) begin
            rd_mux = {{(32-`ANP_IRQ_N){1'b0}}, ien_r};
        end
    end
    assign rb.rd_data = rd_mux;

    anp_axil_slave u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb)
    );

    // strap pins are asynchronous; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_s1_r <= 3'b000;
            strap_s2_r <= 3'b000;
        end else begin
            strap_s1_r <= config_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            strap_done_r <= strap_cnt_r == `ANP_STRAP_WAIT;
        end
    end

    // latched bits: a new event beats the clear of the same read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pdf_lh_r <= 1'b0;
            pgr_lh_r <= 1'b0;
        end else begin
            pdf_lh_r <= par_det_fault | (pdf_lh_r & ~exp_rd);
            pgr_lh_r <= page_rx_stb | (pgr_lh_r & ~exp_rd);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnp_r <= `ANP_LNP_RST;
            toggle_r <= 1'b0;
        end else begin
            lnp_r <= lnp_nxt;
            if (np_tx_stb) begin
                toggle_r <= ~toggle_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pnp_r <= 16'h0000;
        end else if (page_rx_stb) begin
            pnp_r <= partner_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre100_r <= 1'b0;
            pre10_r <= 1'b0;
        end else begin
            if (pre_we) begin
                pre100_r <= rb.wr_data[`ANP_PRE_100];
                pre10_r <= rb.wr_data[`ANP_PRE_10];
            end else if (!strap_done_r && strap_cnt_r == `ANP_STRAP_WAIT) begin
                pre100_r <= strap_s2_r == `ANP_STRAP_100;
            end
        end
    end

    assign irq_evt[`ANP_IRQ_PDF] = par_det_fault;
    assign irq_evt[`ANP_IRQ_PGR] = page_rx_stb;

    genvar gi;
    generate
        for (gi = 0; gi < `ANP_IRQ_N; gi = gi + 1) begin : g_ists
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ists_r[gi] <= 1'b0;
                end else begin
                    ists_r[gi] <= irq_evt[gi] | (ists_r[gi] & ~w1c[gi]);
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_r <= {`ANP_IRQ_N{1'b0}};
            irq <= 1'b0;
        end else begin
            if (ien_we) begin
                ien_r <= rb.wr_data[`ANP_IRQ_N-1:0];
            end
            irq <= |(ists_r & ien_r);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            np_word_out <= `ANP_LNP_RST;
            preamble_100_restore <= 1'b0;
            preamble_10_restore <= 1'b0;
        end else begin
            np_word_out <= lnp_view;
            preamble_100_restore <= pre100_r;
            preamble_10_restore <= pre10_r;
        end
    end

    anp_preamble_filter u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .speed_100(speed_100),
        .restore_100(pre100_r),
        .restore_10(pre10_r),
        .rx_dv_in(rx_dv_in),
        .rxd_in(rxd_in),
        .rx_dv_out(rx_dv_out),
        .rxd_out(rxd_out)
    );
endmodule // anp_regs_top

// ### verif/anp_regs_checker.sv
// Purpose: port-level timing checks on the next-page register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of anp_regs_top
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_regs_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire anp_pkg::anp_resp_t s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire anp_pkg::anp_resp_t s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic speed_100,
    input wire logic np_tx_stb,
    input wire logic [15:0] np_word_out,
    input wire logic preamble_100_restore,
    input wire logic rx_dv_in,
    input wire logic [3:0] rxd_in,
    input wire logic rx_dv_out,
    input wire logic [3:0] rxd_out
);
    import anp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (rd_taken |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer not two cycles after address");
    a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after request");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_error_data: assert property (s_axi_rvalid && s_axi_rresp == ANP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_toggle_flip: assert property (np_tx_stb |=> ##1 np_word_out[11] != $past(np_word_out[11]))
        else $error("toggle did not flip after transmit");
    a_idle_out: assert property (!rx_dv_in |=> !rx_dv_out)
        else $error("output valid without input valid");
    a_pass_data: assert property (rx_dv_in && speed_100 && preamble_100_restore && $stable(preamble_100_restore) |=> rx_dv_out && rxd_out == $past(rxd_in))
        else $error("restored stream not passed through");
endmodule // anp_regs_checker

bind anp_regs_top anp_regs_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .speed_100, .np_tx_stb, .np_word_out,
    .preamble_100_restore, .rx_dv_in, .rxd_in, .rx_dv_out, .rxd_out);

// ### verif/anp_mgmt_master.sv
// Purpose: management-side bus master that reaches the register bank
// Assumes: one write and one read at most in flight
// Notes: waits are unbounded here; the bench watchdog cuts a hang
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_mgmt_master (
    input wire logic aclk,
    output logic [`ANP_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire anp_pkg::anp_resp_t s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [`ANP_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire anp_pkg::anp_resp_t s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    import anp_pkg::*;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} <= '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} <= '0;
        {s_axi_arvalid, s_axi_rready} <= '0;
    end
    // both bytes of the low half are strobed so 16-bit registers update whole
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      output anp_resp_t r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output anp_resp_t r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
endmodule // anp_mgmt_master

// ### verif/anp_regs_top_tb.sv
// Purpose: self-checking bench for the next-page register bank
// Assumes: straps start at the 100 Mbit/s code, 100 MHz clock
// Notes: random values come from a fixed-seed xorshift
`timescale 1ns/1ps
`include "anp_params.svh"
module anp_regs_top_tb;
    import anp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq, rx_dv_out;
    logic preamble_100_restore, preamble_10_restore;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, x, seed, d;
    logic [3:0] s_axi_wstrb, rxd_out, first_nib, rxd_in;
    logic [15:0] np_word_out, partner_word, epw, mctl[4];
    anp_resp_t s_axi_bresp, s_axi_rresp, r;
    logic par_det_fault, lp_next_page_able, lp_autoneg_able, page_rx_stb;
    logic np_tx_stb, speed_100, rx_dv_in, tog;
    logic [2:0] strap;
    int err_count, check_count, out_cnt;
    anp_regs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .config_strap(strap), .speed_100,
        .par_det_fault, .lp_next_page_able, .lp_autoneg_able, .page_rx_stb,
        .partner_word, .np_tx_stb, .rx_dv_in, .rxd_in, .np_word_out,
        .preamble_100_restore, .preamble_10_restore, .rx_dv_out, .rxd_out,
        .irq);
    anp_mgmt_master u_mst (.aclk, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (rx_dv_out === 1'h1) begin
        if (out_cnt == 0) first_nib <= rxd_out;
        out_cnt <= out_cnt + 1;
    end
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expansion word from event and ability bits
    function logic [15:0] exp_word(input logic [3:0] e);
        return {11'h0, e[2], e[0], 1'h1, e[3], e[1]};
    endfunction
    function logic [15:0] lnp(input logic [15:0] w);
        return (w & `ANP_LNP_WR_MASK) | {4'h0, tog, 11'h0};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task chk_resp(input string n, input anp_resp_t e, input anp_resp_t g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [15:0] e);
        u_mst.rd(a, d, r);
        chk("read data", {16'h0, e}, d);
        chk_resp("read resp", ANP_RESP_OKAY, r);
    endtask
    task wrc(input logic [7:0] a, input logic [15:0] v, input anp_resp_t e);
        u_mst.wr(a, v, r);
        chk_resp("write resp", e, r);
    endtask
    task test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done();
    end
    initial begin
        {aresetn, par_det_fault, lp_next_page_able, lp_autoneg_able} = '0;
        {page_rx_stb, np_tx_stb, rx_dv_in, rxd_in, tog, out_cnt} = '0;
        {partner_word, epw, err_count, check_count} = '0;
        speed_100 = 1'h1;
        strap = `ANP_STRAP_100;
        seed = 32'h2033;
        mctl = '{16'h0000, 16'h0080, 16'hff40, 16'h0000};
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        chk("np word", 32'h2001, {16'h0, np_word_out});
        rdc(8'h18, 16'h0004);
        rdc(8'h1c, `ANP_LNP_RST);
        rdc(8'h20, 16'h0000);
        rdc(8'h50, 16'h0081);
        for (int i = 0; i < 6; i++) begin
            x = xs();
            @(posedge aclk);
            {page_rx_stb, par_det_fault, lp_autoneg_able} <= x[3:1];
            lp_next_page_able <= x[0];
            partner_word <= x[31:16];
            @(posedge aclk);
            {page_rx_stb, par_det_fault} <= 2'h0;
            if (x[3]) epw = x[31:16];
            rdc(8'h18, exp_word({x[3:1], x[0]}));
            rdc(8'h18, exp_word({2'h0, x[1:0]}));
            rdc(8'h20, epw);
        end
        wrc(8'h20, 16'hffff, ANP_RESP_OKAY);
        rdc(8'h20, epw);
        wrc(8'h18, 16'hffff, ANP_RESP_OKAY);
        rdc(8'h18, exp_word({2'h0, x[1:0]}));
        wrc(8'h08, 16'hffff, ANP_RESP_SLVERR);
        u_mst.rd(8'h04, d, r);
        chk_resp("unmapped resp", ANP_RESP_SLVERR, r);
        for (int i = 0; i < 3; i++) begin
            x = xs();
            wrc(8'h1c, x[15:0], ANP_RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk("np word", {16'h0, lnp(x[15:0])}, {16'h0, np_word_out});
            np_tx_stb <= 1'h1;
            @(posedge aclk);
            np_tx_stb <= 1'h0;
            tog = ~tog;
            rdc(8'h1c, lnp(x[15:0]));
        end
        // irq: masked event, unmask, then write-one clear
        wrc(8'hc0, 16'h0003, ANP_RESP_OKAY);
        par_det_fault <= 1'h1;
        @(posedge aclk);
        par_det_fault <= 1'h0;
        repeat (3) @(posedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc(8'hc0, 16'h0001);
        wrc(8'hc4, 16'h0001, ANP_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq set", 32'h1, {31'h0, irq});
        wrc(8'hc0, 16'h0001, ANP_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        for (int m = 0; m < 4; m++) begin
            wrc(8'h50, mctl[m], ANP_RESP_OKAY);
            rdc(8'h50, {8'h0, mctl[m][7:6], 6'h01});
            speed_100 <= (m < 2);
            out_cnt = 0;
            repeat (3) @(posedge aclk);
            chk("restore bits", {30'h0, mctl[m][7:6]},
                {30'h0, preamble_100_restore, preamble_10_restore});
            for (int i = 0; i < 20; i++) begin
                rx_dv_in <= 1'h1;
                rxd_in <= i[3:0];
                @(posedge aclk);
            end
            rx_dv_in <= 1'h0;
            repeat (4) @(posedge aclk);
            chk("nibble count", (m == 0) ? 32'h12 : (m == 3) ? 32'h6 : 32'h14, out_cnt);
            chk("first nibble", (m == 0) ? 32'h2 : (m == 3) ? 32'he : 32'h0, {28'h0, first_nib});
        end
        // second reset with a strap code other than 100
        strap <= 3'b010;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        chk("np word", 32'h2001, {16'h0, np_word_out});
        rdc(8'h50, 16'h0001);
        test_done();
    end
endmodule // anp_regs_top_tb
